/* rtl/omc_pkg.sv */
package omc_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_MODE_CONTROL           = 8'h0a;
    localparam logic [7:0] IDX_WAKE_INTERVAL_HIGH     = 8'h0b;
    localparam logic [7:0] IDX_WAKE_INTERVAL_LOW      = 8'h0c;
    localparam logic [7:0] IDX_STANDBY_THRESHOLD_HIGH = 8'h0d;
    localparam logic [7:0] IDX_STANDBY_THRESHOLD_LOW  = 8'h0e;
    localparam logic [7:0] IDX_EVENT_STATUS           = 8'h14;
    localparam logic [7:0] IDX_EVENT_MASK             = 8'h15;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE_CONTROL       = 8'h00;
    localparam logic [7:0] RST_WAKE_INTERVAL_HIGH = 8'h80;
    localparam logic [7:0] RST_WAKE_INTERVAL_LOW  = 8'h00;
    localparam logic [7:0] RST_THRESHOLD          = 8'h00;
    localparam logic [1:0] RST_EVENTS             = 2'h0;

    // ------------------------------------------------------------------
    // Mode control fields, plus the wake unit bit of the wake interval high register
    // ------------------------------------------------------------------
    localparam int MODE_MSB       = 7;
    localparam int MODE_LSB       = 6;
    localparam int DISCARD_MSB    = 5;
    localparam int DISCARD_LSB    = 3;
    localparam int CHOP_EN_BIT    = 2;
    localparam int MEAS_EN_BIT    = 1;
    localparam int START_BIT      = 0;
    localparam int WAKE_UNIT_BIT  = 7;
    localparam logic [3:0] DISCARD_BASE = 4'h3;

    localparam logic [1:0] MODE_NORMAL_1              = 2'h0;
    localparam logic [1:0] MODE_NORMAL_2              = 2'h1;
    localparam logic [1:0] MODE_STANDBY_PERIODIC      = 2'h2;
    localparam logic [1:0] MODE_STANDBY_THRESHOLD     = 2'h3;

    // Event bits in status and mask
    localparam int EV_STARTED = 0;
    localparam int EV_WAKE    = 1;

    // Device run state, Gray along stop -> normal -> standby
    typedef enum logic [1:0] {
        OMC_ST_STOP    = 2'b00,
        OMC_ST_NORMAL  = 2'b01,
        OMC_ST_STANDBY = 2'b11
    } omc_state_type;

    // Byte address of a register index
    function automatic logic [9:0] omc_addr(input logic [7:0] idx);
        omc_addr = {idx, 2'b00};
    endfunction

endpackage

/* rtl/omc_regs.sv */
`timescale 1ns/10ps
// Function
// (R1) Mode field bits 7:6 picks normal 1, normal 2, standby periodic, threshold.
// (R2) Bits 5:3 give discarded cycles before threshold compare, 3 to 10.
// (R3) Bit 2 enables the chopper clock output pin; reset disabled.
// (R4) Bit 1 enables measurement-active pin on standby-to-normal transition; the code pulses it on standby_wake in STANDBY, with no change of state.
// (R5) Bit 0 low holds STOP; high enters mode chosen by bits 7:6.
// (R6) Wake interval unit bit 7 of high register: ms or s, reset 1.
// (R7) Wake interval value is high bits 6:0 then low byte.
// (R8) 16-bit standby threshold from high and low registers, reset zero.
// (R9) All registers load reset values and read back their full byte; event status and mask keep and read back bits 1:0 only.
module omc_regs
    import omc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        standby_wake,
    output logic [1:0]       operating_mode,
    output logic             device_running,
    output logic             standby_active,
    output logic [3:0]       discard_cycles,
    output logic             chopper_clock_out_en,
    output logic             measurement_active_pin,
    output logic             wake_unit_seconds,
    output logic [14:0]      standby_wake_interval,
    output logic [15:0]      standby_threshold,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]    mode_control;
    logic [7:0]    wake_interval_high;
    logic [7:0]    wake_interval_low;
    logic [7:0]    standby_threshold_high;
    logic [7:0]    standby_threshold_low;
    logic [1:0]    event_status;
    logic [1:0]    event_mask;
    omc_state_type state;

    logic [7:0]    next_mode_control;
    logic [7:0]    next_wake_interval_high;
    logic [7:0]    next_wake_interval_low;
    logic [7:0]    next_standby_threshold_high;
    logic [7:0]    next_standby_threshold_low;
    logic [1:0]    next_event_status;
    logic [1:0]    next_event_mask;
    omc_state_type next_state;
    logic [31:0]   next_prdata;
    logic          next_pready;
    logic          next_pslverr;
    logic          next_meas_pin;
    logic          wr_fire;
    logic          rd_fire;
    logic          addr_ok;
    logic [7:0]    rd_byte;
    logic [1:0]    events;

    // Code 0..7 maps to 3..10 discarded cycles
    function automatic logic [3:0] discard_of(input logic [2:0] code);
        discard_of = {1'b0, code} + DISCARD_BASE;
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // One wait state so read data and the error flag come from flops
    always_comb begin
        wr_fire = psel & penable & pready & pwrite;
        rd_fire = psel & penable & pready & ~pwrite;
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            omc_addr(IDX_MODE_CONTROL):           rd_byte = mode_control; // R9
            omc_addr(IDX_WAKE_INTERVAL_HIGH):     rd_byte = wake_interval_high;
            omc_addr(IDX_WAKE_INTERVAL_LOW):      rd_byte = wake_interval_low;
            omc_addr(IDX_STANDBY_THRESHOLD_HIGH):
                rd_byte = standby_threshold_high;
            omc_addr(IDX_STANDBY_THRESHOLD_LOW):
                rd_byte = standby_threshold_low;
            omc_addr(IDX_EVENT_STATUS): rd_byte = {6'h00, event_status};
            omc_addr(IDX_EVENT_MASK):   rd_byte = {6'h00, event_mask};
            default: addr_ok = 1'b0;
        endcase
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~addr_ok;
        next_prdata  = 32'h0000_0000;
        if (psel && penable && !pready && !pwrite) begin
            next_prdata = {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_comb begin
        next_mode_control           = mode_control;
        next_wake_interval_high     = wake_interval_high;
        next_wake_interval_low      = wake_interval_low;
        next_standby_threshold_high = standby_threshold_high;
        next_standby_threshold_low  = standby_threshold_low;
        next_event_mask             = event_mask;
        if (wr_fire) begin
            case (paddr)
                omc_addr(IDX_MODE_CONTROL):
                    next_mode_control = pwdata[7:0]; // R1
                omc_addr(IDX_WAKE_INTERVAL_HIGH):
                    next_wake_interval_high = pwdata[7:0]; // R6
                omc_addr(IDX_WAKE_INTERVAL_LOW):
                    next_wake_interval_low = pwdata[7:0]; // R7
                omc_addr(IDX_STANDBY_THRESHOLD_HIGH):
                    next_standby_threshold_high = pwdata[7:0]; // R8
                omc_addr(IDX_STANDBY_THRESHOLD_LOW):
                    next_standby_threshold_low = pwdata[7:0]; // R8
                omc_addr(IDX_EVENT_MASK):
                    next_event_mask = pwdata[1:0];
                default: next_event_mask = event_mask;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Run state and events
    // ------------------------------------------------------------------
    // State follows the mode field while running, so a mode write
    // takes effect without a pass through STOP
    always_comb begin
        next_state = state;
        case (state)
            OMC_ST_STOP, OMC_ST_NORMAL, OMC_ST_STANDBY: begin
                if (!mode_control[START_BIT]) begin
                    next_state = OMC_ST_STOP; // R5
                end else if (mode_control[MODE_MSB]) begin
                    next_state = OMC_ST_STANDBY; // R5
                end else begin
                    next_state = OMC_ST_NORMAL; // R5
                end
            end
            default: next_state = OMC_ST_STOP;
        endcase
        events = 2'h0;
        events[EV_STARTED] = (state == OMC_ST_STOP)
                             && (next_state != OMC_ST_STOP);
        events[EV_WAKE] = standby_wake && (state == OMC_ST_STANDBY);
        // Pulse only when enabled and standby_wake arrives in standby; the state stays STANDBY
        next_meas_pin = events[EV_WAKE] & mode_control[MEAS_EN_BIT]; // R4
        // Set wins over the read-clear in the same cycle
        next_event_status = event_status;
        if (rd_fire && paddr == omc_addr(IDX_EVENT_STATUS)) begin
            next_event_status = 2'h0;
        end
        next_event_status = next_event_status | events;
    end

    // ------------------------------------------------------------------
    // Flops
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_control           <= RST_MODE_CONTROL; // R9
            wake_interval_high     <= RST_WAKE_INTERVAL_HIGH; // R6
            wake_interval_low      <= RST_WAKE_INTERVAL_LOW;
            standby_threshold_high <= RST_THRESHOLD; // R8
            standby_threshold_low  <= RST_THRESHOLD;
            event_status           <= RST_EVENTS;
            event_mask             <= RST_EVENTS;
            state                  <= OMC_ST_STOP;
            prdata                 <= 32'h0000_0000;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            operating_mode         <= MODE_NORMAL_1;
            device_running         <= 1'b0;
            standby_active         <= 1'b0;
            discard_cycles         <= DISCARD_BASE;
            chopper_clock_out_en   <= 1'b0;
            measurement_active_pin <= 1'b0;
            wake_unit_seconds      <= 1'b1;
            standby_wake_interval  <= 15'h0000;
            standby_threshold      <= 16'h0000;
            irq                    <= 1'b0;
        end else begin
            mode_control           <= next_mode_control;
            wake_interval_high     <= next_wake_interval_high;
            wake_interval_low      <= next_wake_interval_low;
            standby_threshold_high <= next_standby_threshold_high;
            standby_threshold_low  <= next_standby_threshold_low;
            event_status           <= next_event_status;
            event_mask             <= next_event_mask;
            state                  <= next_state;
            prdata                 <= next_prdata;
            pready                 <= next_pready;
            pslverr                <= next_pslverr;
            operating_mode         <= mode_control[MODE_MSB:MODE_LSB]; // R1
            device_running         <= (state != OMC_ST_STOP); // R5
            standby_active         <= (state == OMC_ST_STANDBY);
            discard_cycles <= discard_of(
                mode_control[DISCARD_MSB:DISCARD_LSB]); // R2
            chopper_clock_out_en   <= mode_control[CHOP_EN_BIT]; // R3
            measurement_active_pin <= next_meas_pin;
            wake_unit_seconds <= wake_interval_high[WAKE_UNIT_BIT]; // R6
            standby_wake_interval <= {wake_interval_high[6:0],
                                      wake_interval_low}; // R7
            standby_threshold <= {standby_threshold_high,
                                  standby_threshold_low}; // R8
            irq <= |(event_status & event_mask);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_stop_hold: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        !mode_control[START_BIT] |=> state == OMC_ST_STOP ##1 !device_running)
        else $error("device left STOP with start bit low");

    chk_standby_entry: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        (mode_control[START_BIT] && mode_control[MODE_MSB])
        |=> state == OMC_ST_STANDBY ##1 standby_active)
        else $error("standby mode not entered");

    chk_mode_out: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        wr_fire && paddr == omc_addr(IDX_MODE_CONTROL)
        |-> ##2 operating_mode == $past(pwdata[7:6], 2))
        else $error("operating mode output wrong after write");

    chk_discard_map: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        ##1 discard_cycles == $past(mode_control[5:3]) + 4'h3)
        else $error("discard count mapping wrong");

    chk_chop_gate: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        chopper_clock_out_en == $past(mode_control[CHOP_EN_BIT]))
        else $error("chopper output differs from its enable bit");

    chk_meas_pin: assert property ( // R4
        @(posedge pclk) disable iff (!presetn)
        measurement_active_pin |-> $past(mode_control[MEAS_EN_BIT])
                                   && $past(state) == OMC_ST_STANDBY)
        else $error("measurement pin pulsed while disabled");

    chk_wake_value: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        wr_fire && paddr == omc_addr(IDX_WAKE_INTERVAL_LOW)
        |-> ##2 standby_wake_interval[7:0] == $past(pwdata[7:0], 2))
        else $error("wake interval low part wrong");

    chk_reset_unit: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> wake_interval_high == 8'h80)
        else $error("wake unit not seconds after reset");

    chk_threshold: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        wr_fire && paddr == omc_addr(IDX_STANDBY_THRESHOLD_HIGH)
        |-> ##2 standby_threshold[15:8] == $past(pwdata[7:0], 2))
        else $error("threshold high byte wrong");

    chk_readback: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        rd_fire && paddr == omc_addr(IDX_MODE_CONTROL)
        |-> prdata == {24'h00_0000, mode_control})
        else $error("mode control readback wrong");

    // Bus answer is a single-cycle pulse; a stuck ready would double writes
    chk_pready_pulse: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held for more than one cycle");

    chk_unmapped_err: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        rd_fire && !addr_ok |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    chk_normal_entry: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        (mode_control[START_BIT] && !mode_control[MODE_MSB])
        |=> state == OMC_ST_NORMAL ##1 !standby_active)
        else $error("normal mode not entered");

    chk_wake_unit: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        wake_unit_seconds == $past(wake_interval_high[WAKE_UNIT_BIT]))
        else $error("wake unit output differs from its bit");

    // An event must survive a read-clear that lands in the same cycle
    chk_status_sticky: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        events[EV_STARTED] |=> event_status[EV_STARTED])
        else $error("start event lost from status");

    chk_irq_level: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        irq == $past(|(event_status & event_mask)))
        else $error("interrupt level does not follow status and mask");

    cov_start: cover property (
        @(posedge pclk) disable iff (!presetn) events[EV_STARTED]);
    cov_wake_pin: cover property (
        @(posedge pclk) disable iff (!presetn) measurement_active_pin);
    cov_irq: cover property (
        @(posedge pclk) disable iff (!presetn) $rose(irq));
    cov_slverr: cover property (
        @(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

/* test/omc_regs_tb.sv */
`timescale 1ns/10ps
module omc_regs_tb
    import omc_pkg::*;
();
    // ------------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        standby_wake;
    logic [1:0]  operating_mode;
    logic        device_running;
    logic        standby_active;
    logic [3:0]  discard_cycles;
    logic        chopper_clock_out_en;
    logic        measurement_active_pin;
    logic        wake_unit_seconds;
    logic [14:0] standby_wake_interval;
    logic [15:0] standby_threshold;
    logic        irq;
    int          bad_count;
    int          n_checks;
    int          seed;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  idx_tab [5];
    logic [7:0]  mdl [5];

    omc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .standby_wake(standby_wake), .operating_mode(operating_mode),
        .device_running(device_running), .standby_active(standby_active),
        .discard_cycles(discard_cycles),
        .chopper_clock_out_en(chopper_clock_out_en),
        .measurement_active_pin(measurement_active_pin),
        .wake_unit_seconds(wake_unit_seconds),
        .standby_wake_interval(standby_wake_interval),
        .standby_threshold(standby_threshold), .irq(irq));

    // ------------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Whole run is under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        summarize();
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered right after a rising edge, leaves after one
    // idle edge so the next setup never collides with this release
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer however long it takes; the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [3:0] exp_discard(input logic [2:0] code);
        return 4'h3 + {1'b0, code};
    endfunction

    // Registered outputs sampled at an edge show last cycle's settled value
    task automatic chk_outs();
        repeat (3) @(posedge pclk);
        chk(32'(operating_mode), 32'(mdl[0][7:6]));
        chk(32'(discard_cycles), 32'(exp_discard(mdl[0][5:3])));
        chk(32'(chopper_clock_out_en), 32'(mdl[0][2]));
        chk(32'(wake_unit_seconds), 32'(mdl[1][7]));
        chk(32'(standby_wake_interval), {17'h0, mdl[1][6:0], mdl[2]});
        chk(32'(standby_threshold), {16'h0, mdl[3], mdl[4]});
        chk(32'(device_running), 32'(mdl[0][0]));
    endtask

    task automatic wr_chk(input int k, input logic [31:0] d);
        apb(1'b1, idx_tab[k], d);
        mdl[k] = d[7:0];
        apb(1'b0, idx_tab[k], 32'h0);
        chk(rd, {24'h0, mdl[k]});
        chk(32'(err), 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int k;
        int cnt;
        presetn = 1'b0;
        {psel, penable, pwrite, standby_wake} = 4'h0;
        paddr = 10'h000;
        pwdata = 32'h0;
        seed = 73386;
        idx_tab = '{IDX_MODE_CONTROL, IDX_WAKE_INTERVAL_HIGH,
                    IDX_WAKE_INTERVAL_LOW, IDX_STANDBY_THRESHOLD_HIGH,
                    IDX_STANDBY_THRESHOLD_LOW};
        mdl = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Power-on values, both at the outputs and on read-back
        chk_outs();
        for (k = 0; k < 5; k++) begin
            apb(1'b0, idx_tab[k], 32'h0);
            chk(rd, {24'h0, mdl[k]});
        end
        // Complementary bytes FE and 01 first, then random bytes with junk in the upper lanes
        for (k = 0; k < 5; k++) wr_chk(k, 32'hffff_fffe);
        chk_outs();
        for (k = 0; k < 5; k++) wr_chk(k, 32'h0000_0001);
        chk_outs();
        repeat (30) begin
            k = ($random(seed) & 32'h7fff_ffff) % 5;
            wr_chk(k, $random(seed));
            chk_outs();
        end
        // Mid-run reset: every register and output back to power-on values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        mdl = '{RST_MODE_CONTROL, RST_WAKE_INTERVAL_HIGH,
                RST_WAKE_INTERVAL_LOW, RST_THRESHOLD, RST_THRESHOLD};
        @(posedge pclk);
        chk_outs();
        chk(32'(irq), 32'h0);
        chk(32'(standby_active), 32'h0);
        for (k = 0; k < 5; k++) begin
            apb(1'b0, idx_tab[k], 32'h0);
            chk(rd, {24'h0, mdl[k]});
        end
        apb(1'b0, IDX_EVENT_STATUS, 32'h0);
        chk(rd, 32'h0);
        // Unmapped word is refused in both directions
        apb(1'b1, 8'h0f, 32'h5a);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h0f, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        // Each mode from STOP: start event, irq, read-to-clear
        for (k = 0; k < 4; k++) begin
            wr_chk(0, 32'h0);
            apb(1'b1, IDX_EVENT_MASK, 32'h1);
            apb(1'b0, IDX_EVENT_STATUS, 32'h0);
            chk_outs();
            wr_chk(0, {24'h0, k[1:0], 6'h39});
            chk_outs();
            chk(32'(standby_active), 32'(k[1]));
            chk(32'(irq), 32'h1);
            apb(1'b0, IDX_EVENT_STATUS, 32'h0);
            chk(rd, 32'h1);
            repeat (3) @(posedge pclk);
            chk(32'(irq), 32'h0);
        end
        // Wake from standby, indicator pin disabled then enabled
        for (k = 0; k < 2; k++) begin
            wr_chk(0, 32'h0);
            apb(1'b1, IDX_EVENT_MASK, 32'h2);
            apb(1'b0, IDX_EVENT_MASK, 32'h0);
            chk(rd, 32'h2);
            wr_chk(0, {24'h0, 6'h20, k[0], 1'b1});
            apb(1'b0, IDX_EVENT_STATUS, 32'h0);
            chk_outs();
            standby_wake <= 1'b1;
            @(posedge pclk);
            standby_wake <= 1'b0;
            cnt = 0;
            repeat (4) begin
                @(posedge pclk);
                cnt += int'(measurement_active_pin === 1'b1);
            end
            chk(32'(cnt), 32'(k));
            chk(32'(irq), 32'h1);
            apb(1'b0, IDX_EVENT_STATUS, 32'h0);
            chk(rd, 32'h2);
        end
        summarize();
    end
endmodule
